// *** bench/fie_sensor_model.sv ***
// Model of the field wiring and sensors at the input pins
`timescale 1ns/1ps
`default_nettype none
// ****
// Sensor model
// ****
// Safety addresses are software matter and need no pins
module fie_sensor_model (
   input wire logic [1:0] vs_en,
   input wire logic [7:0] sens,
   output logic [7:0] din
);
   wire logic [7:0] powered; // Supply 0 feeds 0-3, supply 1 feeds 4-7
   assign powered = {{4{vs_en[1]}}, {4{vs_en[0]}}};
   // Unpowered switch reads low, so a healthy input drops during a test
   assign din = sens & powered;
endmodule
`default_nettype wire

// *** bench/testbench.sv ***
// Self-checking bench of the input evaluation block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   typedef struct {logic [31:0] d; logic [31:0] m; logic e;} fie_note_t;
   logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00, sens = 8'h00, din, proc_val, passivated;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, diag_irq;
   logic [1:0] vs_en;
   logic [7:0] irq_cnt = 8'h00, rnd = 8'h14;
   int errors = 0, cmp_count = 0, cyc = 0;
   fie_note_t notes[$]; // Expected APB answers, oldest first
   fie_core fie_core_inst (.clk(clk), .sys_rst(sys_rst), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .din(din),
      .vs_en(vs_en), .proc_val(proc_val), .passivated(passivated),
      .diag_irq(diag_irq));
   fie_sensor_model fie_sensor_model_inst (.vs_en(vs_en), .sens(sens),
      .din(din));
   // ****
   // Clock, timeout, monitor
   // ****
   initial begin
      forever #25 clk = ~clk;
   end
   // Ceiling well above the two long discrepancy waits
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         errors++;
         finish_test();
      end
   end
   // Takes the oldest note whenever a transfer completes
   always @(posedge clk) begin
      fie_note_t n;
      if (diag_irq === 1'b1) irq_cnt <= irq_cnt + 8'h01;
      if (psel && penable && pready === 1'b1) begin
         n = notes.pop_front();
         chk_apb(n.d & n.m, prdata & n.m, n.e, pslverr);
      end
   end
   // ****
   // Tasks
   // ****
   task automatic chk_apb(input logic [31:0] x, input logic [31:0] g,
         input logic xe, input logic ge);
      cmp_count++;
      if ({xe, x} !== {ge, g}) begin
         errors++;
         $display("Error apb answer expected %h/%h seen %h/%h", xe, x, ge, g);
      end
   endtask
   task automatic chk_port(input string nm, input logic [7:0] x,
         input logic [7:0] g);
      cmp_count++;
      if (x !== g) begin
         errors++;
         $display("Error %s expected %h seen %h", nm, x, g);
      end
   endtask
   // One APB transfer, held until pready is seen high
   task automatic apb(input logic [7:0] a, input logic w,
         input logic [31:0] d, input logic [31:0] m, input logic e);
      notes.push_back('{d: w ? 32'h0 : d, m: m, e: e});
      @(posedge clk);
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      psel <= 1'b1;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(a, 1'b1, d, 32'h0, 1'b0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(a, 1'b0, x, 32'hffff_ffff, 1'b0);
   endtask
   // Drive sensors, let the synchroniser settle, check both outputs
   task automatic step(input logic [7:0] s, input int w,
         input logic [7:0] xv, input logic [7:0] xp);
      @(posedge clk);
      sens <= s;
      repeat (w) @(posedge clk);
      // Look mid-cycle, where the registered outputs have settled
      @(negedge clk);
      chk_port("proc_val", xv, proc_val);
      chk_port("passivated", xp, passivated);
   endtask
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic finish_test();
      $display("errors=%0d comparisons=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // ****
   // Main sequence
   // ****
   initial begin
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      rd(fie_pkg::A_CFG, fie_pkg::RST_CFG);
      rd(fie_pkg::A_CHAN, fie_pkg::RST_CHAN);
      rd(fie_pkg::A_SUPP, fie_pkg::RST_SUPP);
      rd(fie_pkg::A_PAIR, fie_pkg::RST_PAIR);
      rd(fie_pkg::A_SCT, fie_pkg::RST_SCT);
      rd(fie_pkg::A_DISC, fie_pkg::RST_DISC);
      rd(fie_pkg::A_ACK, 32'h0);
      apb(8'h20, 1'b0, 32'h0, 32'hffff_ffff, 1'b1);
      wr(fie_pkg::A_SUPP, 32'h0000_aa55);
      wr(fie_pkg::A_SCT, 32'h0002_0004);
      wr(fie_pkg::A_DISC, 32'h0000_0004);
      wr(fie_pkg::A_CHAN, 32'h0000_ffff);
      wr(fie_pkg::A_PAIR, 32'h0000_0001);
      step(8'h11, 12, 8'h01, 8'h00);
      step(8'h10, 12, 8'h01, 8'h00);
      step(8'h10, 1000, 8'h01, 8'h00);
      step(8'h11, 12, 8'h01, 8'h00);
      step(8'h01, 10100, 8'h00, 8'h11);
      chk_port("irq_cnt", 8'h01, irq_cnt);
      step(8'h11, 12, 8'h01, 8'h00);
      wr(fie_pkg::A_PAIR, 32'h0000_0101);
      step(8'h10, 8, 8'h00, 8'h00);
      step(8'h11, 12, 8'h01, 8'h00);
      wr(fie_pkg::A_CFG, 32'h0000_0005);
      step(8'h01, 10100, 8'h00, 8'hff);
      chk_port("irq_cnt", 8'h02, irq_cnt);
      step(8'h11, 20, 8'h00, 8'hff);
      wr(fie_pkg::A_ACK, 32'h0000_00ff);
      step(8'h11, 12, 8'h01, 8'h00);
      wr(fie_pkg::A_PAIR, 32'h0000_0002);
      step(8'h01, 12, 8'h01, 8'h00);
      wr(fie_pkg::A_PAIR, 32'h0000_0000);
      for (int i = 0; i < 6; i++) begin
         rnd = lfsr(rnd);
         step(rnd, 12, rnd, 8'h00);
      end
      repeat (4) @(posedge clk);
      // Short test disabled, so both supplies stay on
      chk_port("vs_en", 8'h03, {6'h00, vs_en});
      finish_test();
   end
endmodule
`default_nettype wire

// *** hw/fie_core.sv ***
// Fail-safe eight-channel input evaluation with APB register access
// Summary of operation
// - Channel fault passivates module or channel
// - Adjustable mode uses per-channel acknowledge setting
// - Module passivation uses one common reintegration
// - Short test only on internally supplied channels
// - Supply off exactly configured test time
// - No zero while off gives short diagnostic
// - Short raises diagnostic interrupt, passivates input
// - Detect shorts to supply and neighbours; neighbour shorts caught only when the neighbour's supply stays on
// - Report pre-test value during whole test
// - Wait startup time before evaluating again
// - Single, equivalent and non-equivalent evaluation
// - Pairs compared continuously for expected relation
// - Mismatch onset starts discrepancy timer
// - Mismatch at expiry declares discrepancy error
// - Substitute last valid or zero while timing
// - Last valid held until clear or error
// - Zero substitute delivered immediately on mismatch
// - Pair is channel n with n+4
// - Zero test gates discrepancy error correction
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module fie_core (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic [7:0] din,
   output logic [1:0] vs_en,
   output logic [7:0] proc_val,
   output logic [7:0] passivated,
   output logic diag_irq
);
   // ****************************************************
   // Input synchronisers
   // ****************************************************
   logic [7:0] s1, s2, s3; // Three-stage pin synchroniser
   logic [7:0] din_f;      // Accepted input level

   // Level is accepted once stages two and three agree
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s1 <= 8'h00;
         s2 <= 8'h00;
         s3 <= 8'h00;
         din_f <= 8'h00;
      end else begin
         s1 <= din;
         s2 <= s1;
         s3 <= s2;
         din_f <= (s2 & s3) | (din_f & (s2 ^ s3));
      end
   end

   // ****************************************************
   // 100 us time base shared by all timers
   // ****************************************************
   localparam logic [15:0] TICK_MAX = 16'(fie_pkg::TICK_CYC - 1);
   logic [15:0] pre; // Prescaler
   logic tick;       // One cycle per time base step

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pre <= 16'h0000;
         tick <= 1'b0;
      end else begin
         tick <= pre == TICK_MAX;
         pre <= (pre == TICK_MAX) ? 16'h0000 : pre + 16'h0001;
      end
   end

   // ****************************************************
   // APB slave and configuration registers
   // ****************************************************
   logic [31:0] cfg, chan, supp, pair, sct, disc; // Settings
   logic [7:0] ack_w;                             // Ack pulses
   logic [31:0] stat;                             // Live status
   wire setup = psel && penable && !pready;
   wire wr = psel && penable && pready && pwrite;
   wire hit_cfg = paddr == fie_pkg::A_CFG;
   wire hit_chan = paddr == fie_pkg::A_CHAN;
   wire hit_supp = paddr == fie_pkg::A_SUPP;
   wire hit_pair = paddr == fie_pkg::A_PAIR;
   wire hit_sct = paddr == fie_pkg::A_SCT;
   wire hit_disc = paddr == fie_pkg::A_DISC;
   wire hit_ack = paddr == fie_pkg::A_ACK;
   wire hit_stat = paddr == fie_pkg::A_STAT;
   wire mapped = hit_cfg | hit_chan | hit_supp | hit_pair | hit_sct |
      hit_disc | hit_ack | hit_stat;
   wire [31:0] rd_mux = hit_cfg ? cfg : hit_chan ? chan :
      hit_supp ? supp : hit_pair ? pair : hit_sct ? sct :
      hit_disc ? disc : hit_stat ? stat : 32'h0000_0000;

   // One wait state: answer registered in the first access cycle
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         prdata <= setup ? rd_mux : 32'h0000_0000;
         pslverr <= setup && !mapped;
      end
   end

   // Settings change only at the completing edge of a write
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cfg <= fie_pkg::RST_CFG;
         chan <= fie_pkg::RST_CHAN;
         supp <= fie_pkg::RST_SUPP;
         pair <= fie_pkg::RST_PAIR;
         sct <= fie_pkg::RST_SCT;
         disc <= fie_pkg::RST_DISC;
         ack_w <= 8'h00;
      end else begin
         ack_w <= (wr && hit_ack) ? pwdata[7:0] : 8'h00;
         if (wr && hit_cfg) cfg <= pwdata;
         if (wr && hit_chan) chan <= pwdata;
         if (wr && hit_supp) supp <= pwdata;
         if (wr && hit_pair) pair <= pwdata;
         if (wr && hit_sct) sct <= pwdata;
         if (wr && hit_disc) disc <= pwdata;
      end
   end

   // Field views of the settings
   wire mod_pas = cfg[0];                     // Whole-module passivation
   wire [1:0] reint = cfg[2:1];               // Reintegration type
   wire [7:0] act = chan[7:0];                // Channel activated
   wire [7:0] ack_auto = chan[15:8];          // Per-channel auto ack
   wire [7:0] sc_en = supp[23:16];            // Short test enable
   wire [15:0] off_tk = sct[15:0];            // Supply-off ticks
   wire [15:0] start_tk = sct[31:16];         // Sensor startup ticks

   // ****************************************************
   // Short-circuit test, one sequencer per supply
   // ****************************************************
   // Supply select per channel: 0 external, 1 first, 2 second
   logic [7:0] on_vs0, on_vs1; // Channels fed by each supply
   logic [1:0] sc_busy;        // Test running per supply
   logic [7:0] sc_f0, sc_f1, sc_p0, sc_p1; // Fault and pass pulses
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         on_vs0[i] = supp[2*i +: 2] == 2'h1;
         on_vs1[i] = supp[2*i +: 2] == 2'h2;
      end
   end
   wire [7:0] m0 = on_vs0 & sc_en & act;
   wire [7:0] m1 = on_vs1 & sc_en & act;

   // Sequencers also run the startup wait after the supply returns
   fie_sc_seq u_sc0 (
      .clk(clk),
      .sys_rst(sys_rst),
      .tick(tick),
      .off_tk(off_tk),
      .start_tk(start_tk),
      .mask(m0),
      .din(din_f),
      .supply_on(vs_en[0]),
      .busy(sc_busy[0]),
      .fault(sc_f0),
      .pass(sc_p0)
   );
   fie_sc_seq u_sc1 (
      .clk(clk),
      .sys_rst(sys_rst),
      .tick(tick),
      .off_tk(off_tk),
      .start_tk(start_tk),
      .mask(m1),
      .din(din_f),
      .supply_on(vs_en[1]),
      .busy(sc_busy[1]),
      .fault(sc_f1),
      .pass(sc_p1)
   );

   // Channels frozen over off time plus startup time
   wire [7:0] in_test = (m0 & {8{sc_busy[0]}}) | (m1 & {8{sc_busy[1]}});
   logic [7:0] held; // Value valid just before the test
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         held <= 8'h00;
      end else begin
         held <= (in_test & held) | (~in_test & din_f);
      end
   end
   wire [7:0] ev = (in_test & held) | (~in_test & din_f);

   // ****************************************************
   // Pair evaluation, channel n with channel n+4
   // ****************************************************
   logic [3:0] pval, perr, ptim; // Pair value, error, timer running
   logic [3:0] two_ch;           // Pair merged into one signal
   for (genvar p = 0; p < 4; p++) begin : g_pair
      assign two_ch[p] = pair[2*p +: 2] == fie_pkg::FIE_EV_EQ ||
         pair[2*p +: 2] == fie_pkg::FIE_EV_NEQ;
      fie_pair_eval u_pe (
         .clk(clk),
         .sys_rst(sys_rst),
         .tick(tick),
         .mode(pair[2*p +: 2]),
         .zero_sub(pair[8+p]),
         .zero_test(pair[12+p]),
         .disc_tk(disc[15:0]),
         .a(ev[p]),
         .b(ev[p+4]),
         .value(pval[p]),
         .err(perr[p]),
         .timing(ptim[p])
      );
   end
   // Merged pair reports on channel n, channel n+4 reads zero
   wire [7:0] val = {ev[7:4] & ~two_ch,
      (ev[3:0] & ~two_ch) | (pval & two_ch)};
   wire [3:0] perr_on = perr & two_ch;

   // ****************************************************
   // Fault latches, passivation and reintegration
   // ****************************************************
   logic [7:0] sc_bad;  // Short present until a later test passes
   logic [3:0] perr_q;  // Pair error one cycle back
   logic [7:0] flt;     // Channel passivated by its own fault
   wire [7:0] sc_new = (sc_f0 | sc_f1) & act;
   wire [3:0] perr_rise = perr_on & ~perr_q;
   wire [7:0] new_flt = sc_new | {perr_rise, perr_rise};
   wire [7:0] cause = sc_bad | {perr_on, perr_on};
   wire all_auto = reint == fie_pkg::FIE_RE_AUTO;
   // Whole-module passivation ignores per-channel choice
   wire [7:0] auto_re = (!mod_pas && reint == fie_pkg::FIE_RE_ADJ) ?
      ack_auto : {8{all_auto}};
   wire [7:0] clr = ~cause & (auto_re | ack_w);
   wire any_flt = |flt;

   // A new fault in the clearing cycle keeps the latch set
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sc_bad <= 8'h00;
         perr_q <= 4'h0;
         flt <= 8'h00;
      end else begin
         perr_q <= perr_on;
         sc_bad <= sc_new | (sc_bad & ~(sc_p0 | sc_p1));
         flt <= (new_flt | (flt & ~clr)) & act;
      end
   end
   wire [7:0] pas_n = act & (mod_pas ? {8{any_flt}} : flt);

   // ****************************************************
   // Registered outputs toward the controller
   // ****************************************************
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         passivated <= 8'h00;
         proc_val <= 8'h00;
         diag_irq <= 1'b0;
         stat <= 32'h0000_0000;
      end else begin
         passivated <= pas_n;
         proc_val <= val & act & ~pas_n;
         diag_irq <= |new_flt;
         stat <= {2'h0, vs_en, perr_on, sc_bad, pas_n, val & act};
      end
   end

   // ****************************************************
   // Checks
   // ****************************************************
   pas_value_a: assert property (@(posedge clk) disable iff (sys_rst)
      (passivated & proc_val) == 8'h00)
      else $error("passivated channel shows a value");
   short_irq_a: assert property (@(posedge clk) disable iff (sys_rst)
      |sc_new |=> diag_irq ##1 (passivated & $past(sc_new, 2)) ==
      $past(sc_new, 2))
      else $error("short not reported or not passivated");
   module_pas_a: assert property (@(posedge clk) disable iff (sys_rst)
      mod_pas && $stable(mod_pas) && any_flt |=> passivated == $past(act))
      else $error("module passivation incomplete");
   apb_wait_a: assert property (@(posedge clk) disable iff (sys_rst)
      psel && !penable ##1 psel && penable |-> !pready ##1 pready)
      else $error("apb answer not after one wait state");
endmodule
`default_nettype wire

// *** hw/fie_pair_eval.sv ***
// Two-channel discrepancy evaluation for one channel pair
`timescale 1ns/1ps
`default_nettype none
module fie_pair_eval (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic tick,
   input wire logic [1:0] mode,
   input wire logic zero_sub,
   input wire logic zero_test,
   input wire logic [15:0] disc_tk,
   input wire logic a,
   input wire logic b,
   output logic value,
   output logic err,
   output logic timing
);
   logic [15:0] cnt; // Discrepancy ticks left
   logic last;       // Last valid pair value
   wire neq = mode == fie_pkg::FIE_EV_NEQ;
   wire two = mode == fie_pkg::FIE_EV_EQ || neq;
   wire bad = two && fie_pkg::pair_bad(neq, a, b);
   // Both at zero for equivalent, pair result zero when inverted
   wire zero_ok = !a && (neq || !b);
   wire cured = zero_test ? zero_ok : !bad;

   // ****************************************************
   // Discrepancy timer and error latch
   // ****************************************************
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         err <= 1'b0;
         timing <= 1'b0;
         cnt <= 16'h0000;
         last <= 1'b0;
      end else if (err) begin
         if (cured) begin
            err <= 1'b0;
         end
      end else if (timing) begin
         if (!bad) begin
            timing <= 1'b0;
         end else if (tick && cnt <= 16'h0001) begin
            err <= 1'b1;
            timing <= 1'b0;
         end else if (tick) begin
            cnt <= cnt - 16'h0001;
         end
      end else if (bad) begin
         timing <= 1'b1;
         cnt <= disc_tk;
      end else begin
         last <= a;
      end
   end

   // Substitute while mismatch stands, zero from the first cycle
   assign value = err ? 1'b0 :
      (timing || bad) ? (!zero_sub && last) : a;

   zero_sub_a: assert property (@(posedge clk) disable iff (sys_rst)
      bad && zero_sub |-> !value)
      else $error("nonzero value during discrepancy");
   hold_last_a: assert property (@(posedge clk) disable iff (sys_rst)
      timing && !zero_sub && !err |-> value == last && $stable(last))
      else $error("last valid value not held");
   err_cause_a: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(err) |-> $past(timing) && $past(bad) && $past(tick))
      else $error("error without expired timer");
endmodule
`default_nettype wire

// *** hw/fie_sc_seq.sv ***
// Short-circuit test sequencer for one internal sensor supply
`timescale 1ns/1ps
`default_nettype none
module fie_sc_seq (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic tick,
   input wire logic [15:0] off_tk,
   input wire logic [15:0] start_tk,
   input wire logic [7:0] mask,
   input wire logic [7:0] din,
   output logic supply_on,
   output logic busy,
   output logic [7:0] fault,
   output logic [7:0] pass
);
   fie_pkg::fie_sc_state_t state; // Sequencer state
   logic [15:0] cnt;              // Ticks left in phase, gap ticks counted up in idle
   logic [7:0] seen;              // Channel read zero while off
   logic [7:0] tmask;             // Channels under this test
   wire last_tk = tick && cnt <= 16'h0001;

   // ****************************************************
   // Sequence: idle gap, supply off, sensor startup
   // ****************************************************
   // Starts only on a tick so the off phase is whole ticks long
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= fie_pkg::FIE_SC_IDLE;
         cnt <= 16'h0000;
         seen <= 8'h00;
         tmask <= 8'h00;
         supply_on <= 1'b1;
         busy <= 1'b0;
         fault <= 8'h00;
         pass <= 8'h00;
      end else begin
         fault <= 8'h00;
         pass <= 8'h00;
         case (state)
            fie_pkg::FIE_SC_IDLE: begin
               if (tick && cnt < fie_pkg::SC_GAP_TK) begin
                  cnt <= cnt + 16'h0001;
               end else if (tick && mask != 8'h00) begin
                  state <= fie_pkg::FIE_SC_OFF;
                  supply_on <= 1'b0;
                  busy <= 1'b1;
                  cnt <= off_tk;
                  tmask <= mask;
                  seen <= 8'h00;
               end
            end
            fie_pkg::FIE_SC_OFF: begin
               seen <= seen | ~din; // Any zero clears suspicion
               if (last_tk) begin
                  supply_on <= 1'b1;
                  fault <= tmask & ~(seen | ~din);
                  pass <= tmask & (seen | ~din);
                  state <= fie_pkg::FIE_SC_START;
                  cnt <= start_tk;
               end else if (tick) begin
                  cnt <= cnt - 16'h0001;
               end
            end
            fie_pkg::FIE_SC_START: begin
               // Inputs ignored while the sensor settles
               if (last_tk) begin
                  state <= fie_pkg::FIE_SC_IDLE;
                  busy <= 1'b0;
                  cnt <= 16'h0000;
               end else if (tick) begin
                  cnt <= cnt - 16'h0001;
               end
            end
            default: state <= fie_pkg::FIE_SC_IDLE;
         endcase
      end
   end

   // Supply is off for the whole off phase
   supply_off_a: assert property (@(posedge clk) disable iff (sys_rst)
      state == fie_pkg::FIE_SC_OFF |-> !supply_on)
      else $error("supply on during off phase");
   // Faults are reported only as the supply comes back
   fault_time_a: assert property (@(posedge clk) disable iff (sys_rst)
      |fault |-> supply_on && !$past(supply_on) && busy)
      else $error("short fault outside off end");
endmodule
`default_nettype wire

// *** inc/fie_pkg.sv ***
// Shared constants and types of the fail-safe input evaluation block
`default_nettype none
package fie_pkg;
   // ****************************************************
   // Register offsets (byte addresses on APB)
   // ****************************************************
   localparam logic [7:0] A_CFG = 8'h00;   // Fault policy
   localparam logic [7:0] A_CHAN = 8'h04;  // Activation, ack mode
   localparam logic [7:0] A_SUPP = 8'h08;  // Supply select, test enable
   localparam logic [7:0] A_PAIR = 8'h0c;  // Pair evaluation setup
   localparam logic [7:0] A_SCT = 8'h10;   // Test and startup times
   localparam logic [7:0] A_DISC = 8'h14;  // Discrepancy time
   localparam logic [7:0] A_ACK = 8'h18;   // Manual acknowledge
   localparam logic [7:0] A_STAT = 8'h1c;  // Live status
   // ****************************************************
   // Values after reset (times in 100 us ticks)
   // ****************************************************
   localparam logic [31:0] RST_CFG = 32'h0000_0000;
   localparam logic [31:0] RST_CHAN = 32'h0000_00ff;
   localparam logic [31:0] RST_SUPP = 32'h00ff_0000;
   localparam logic [31:0] RST_PAIR = 32'h0000_0055;
   localparam logic [31:0] RST_SCT = 32'h002a_002a;
   localparam logic [31:0] RST_DISC = 32'h0000_0032;
   // ****************************************************
   // Time base
   // ****************************************************
   localparam int CLK_NS = 50;         // 20 MHz clock
   localparam int TICK_NS = 100000;    // 100 us time base
   localparam int TICK_CYC = TICK_NS / CLK_NS;
   localparam logic [15:0] SC_GAP_TK = 16'h03e8; // 100 ms between tests
   // ****************************************************
   // Enumerations
   // ****************************************************
   typedef enum logic [1:0] {FIE_RE_ADJ, FIE_RE_AUTO, FIE_RE_MAN,
      FIE_RE_RSV} fie_reint_t;
   typedef enum logic [1:0] {FIE_EV_1OO1, FIE_EV_EQ, FIE_EV_NEQ,
      FIE_EV_RSV} fie_eval_t;
   typedef enum logic [1:0] {FIE_SC_IDLE, FIE_SC_OFF,
      FIE_SC_START} fie_sc_state_t;
   // Pair relation broken: differing levels, or equal when inverted
   function automatic logic pair_bad(input logic neq, input logic a,
         input logic b);
      pair_bad = neq ? (a == b) : (a != b);
   endfunction
endpackage
`default_nettype wire
